// file: include/flash_host_pkg.sv
// Purpose: Constants and types for the parallel flash command host.
// Assumes: Host clock CLK_IN at 10 MHz; flash pins driven directly.
// Notes:   Summary of operation
// Summary of operation
// - Write only with strobe and select low
// - Program uses two unlock writes and A0H then data
// - Sector erase uses six writes, code 30H
// - Completed status is confirmed by two more reads
// - Exit identification with single F0H write
package flash_host_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 17'h05555;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 17'h02AAA;
    localparam logic [ADDR_W-1:0] ADDR_ID_MFR  = 17'h00000;
    localparam logic [ADDR_W-1:0] ADDR_ID_DEV  = 17'h00001;
    localparam logic [DATA_W-1:0] CODE_UNLOCK1 = 8'hAA;
    localparam logic [DATA_W-1:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [DATA_W-1:0] CODE_PROGRAM = 8'hA0;
    localparam logic [DATA_W-1:0] CODE_ERASE   = 8'h80;
    localparam logic [DATA_W-1:0] CODE_ID_IN   = 8'h90;
    localparam logic [DATA_W-1:0] CODE_ID_EXIT = 8'hF0;
    localparam logic [DATA_W-1:0] CODE_SECTOR  = 8'h30;
    localparam logic [DATA_W-1:0] CODE_CHIP    = 8'h10;
    localparam int SECTOR_LSB   = 12;     // Uniform 4 KByte sectors
    localparam int STATUS_BIT   = 7;      // inverted_data_status_bit
    localparam int TOGGLE_BIT   = 6;      // alternating_status_bit
    localparam int CLK_MHZ      = 10;
    localparam int STROBE_NS    = 200;    // Write strobe low time
    localparam int STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_NS      = 200;    // Read access wait
    localparam int READ_CYC     = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int PROG_US      = 30;     // Max byte program time
    localparam int PROG_CYC     = PROG_US * CLK_MHZ;
    localparam int RECHECK_N    = 2;      // Extra confirmation reads
    localparam int CNT_W        = 12;
    localparam int POLL_LIMIT   = 4095;   // Poll reads before timeout
    localparam int SEQ_MAX      = 6;

    // Operation codes from the user side
    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE,
        OP_ID_READ, OP_ID_EXIT
    } op_t;

    // One bus write: address plus data
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_word_t;

    // Request from the user
    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } request_t;

    // Answer to the user
    typedef struct packed {
        logic              ok;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] data_hi;
    } answer_t;
endpackage : flash_host_pkg

// file: logic/flash_host.sv
// Purpose: Drives a parallel flash: reads, program, erase, identification.
// Assumes: Pins synchronous to CLK_IN; one request at a time.
// Notes:   Busy polling uses both status bits with a re-read on mismatch.
`timescale 1ns/100ps
module flash_host
    import flash_host_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK_IN,
    input  wire logic              RESET_N_IN,
    // User request
    input  wire logic              REQ_VALID_IN,
    input  wire request_t          REQ_IN,
    output logic                   REQ_READY_OUT,
    // User answer
    output logic                   ANS_VALID_OUT,
    output answer_t                ANS_OUT,
    // Flash pins
    output logic [ADDR_W-1:0]      ADDR_OUT,
    output logic                   CHIP_SEL_N_OUT,
    output logic                   OUT_GATE_N_OUT,
    output logic                   WR_STROBE_N_OUT,
    output logic [DATA_W-1:0]      DATA_LINES_OUT,
    output logic                   DATA_LINES_OE_N_OUT,
    input  wire logic [DATA_W-1:0] DATA_LINES_IN
);
    typedef enum {
        S_IDLE, S_LOOKUP, S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_DONE,
        S_POLL, S_POLL_DONE, S_ANSWER, S_WR_END
    } state_t;

    typedef struct packed {
        logic              cs_n;
        logic              oe_n;
        logic              we_n;
        logic              drive_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } pins_t;

    // Reset release through two flip-flops
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    state_t            state, next_state;
    request_t          req, next_req;
    pins_t             pins, next_pins;
    answer_t           ans, next_ans;
    logic              ans_valid, next_ans_valid;
    logic [2:0]        step, next_step;
    logic [2:0]        last_step, next_last_step;
    logic [CNT_W-1:0]  cnt, next_cnt;
    logic [CNT_W-1:0]  polls, next_polls;
    logic [1:0]        recheck, next_recheck;
    logic [1:0]        id_reads, next_id_reads;
    logic [DATA_W-1:0] prev_rd, next_prev_rd;
    logic [DATA_W-1:0] poll_rd, next_poll_rd;
    logic              first_poll, next_first_poll;
    bus_word_t         rom_word;

    // Command word table
    flash_seq_rom u_rom (
        .clk_in    (CLK_IN),
        .op_in     (req.op),
        .step_in   (step),
        .target_in ({req.addr, req.data}),
        .word_out  (rom_word)
    );

    // Number of bus writes per operation
    function automatic logic [2:0] seq_len(input op_t op);
        unique case (op)
            OP_PROGRAM:      seq_len = 3'h4;
            OP_SECTOR_ERASE: seq_len = 3'h6;
            OP_CHIP_ERASE:   seq_len = 3'h6;
            OP_ID_READ:      seq_len = 3'h3;
            OP_ID_EXIT:      seq_len = 3'h1;
            default:         seq_len = 3'h0;
        endcase
    endfunction : seq_len

    // Status read shows completion for this operation
    function automatic logic status_done(input logic [DATA_W-1:0] now_rd,
                                         input logic [DATA_W-1:0] was_rd,
                                         input request_t r);
        logic want7;
        want7 = (r.op == OP_PROGRAM) ? r.data[STATUS_BIT] : 1'b1;
        status_done = (now_rd[STATUS_BIT] == want7)
                    && (now_rd[TOGGLE_BIT] == was_rd[TOGGLE_BIT]);
    endfunction : status_done

    // Next state and pin values
    always_comb
    begin
        next_state      = state;
        next_req        = req;
        next_pins       = pins;
        next_ans        = ans;
        next_ans_valid  = 1'b0;
        next_step       = step;
        next_last_step  = last_step;
        next_cnt        = cnt;
        next_polls      = polls;
        next_recheck    = recheck;
        next_id_reads   = id_reads;
        next_prev_rd    = prev_rd;
        next_poll_rd    = poll_rd;
        next_first_poll = first_poll;
        unique case (state)
            S_IDLE:
            begin
                next_pins = '{1'b1, 1'b1, 1'b1, 1'b1, pins.addr, pins.data};
                if (REQ_VALID_IN)
                begin
                    next_req       = REQ_IN;
                    next_step      = 3'h0;
                    next_id_reads  = 2'h0;
                    next_ans       = '0;
                    next_last_step = seq_len(REQ_IN.op);
                    if (REQ_IN.op == OP_READ || REQ_IN.op == OP_ID_EXIT)
                        next_step = (REQ_IN.op == OP_ID_EXIT) ? 3'h6 : 3'h0;
                    if (REQ_IN.op == OP_READ)
                    begin
                        next_pins = '{1'b0, 1'b0, 1'b1, 1'b1, REQ_IN.addr, pins.data};
                        next_cnt  = CNT_W'(READ_CYC);
                        next_state = S_RD_LOW;
                    end
                    else
                        next_state = S_LOOKUP;
                end
            end
            S_LOOKUP:
                next_state = S_WR_LOW;
            S_WR_LOW:
            begin
                // Address set while strobe falls; gate high blocks no write
                next_pins = '{1'b0, 1'b1, 1'b0, 1'b0, rom_word.addr, rom_word.data};
                if (req.op == OP_ID_EXIT)
                    next_pins.data = CODE_ID_EXIT;
                next_cnt   = CNT_W'(STROBE_CYC);
                next_state = S_WR_HIGH;
            end
            S_WR_HIGH:
            begin
                if (cnt > CNT_W'(1))
                    next_cnt = cnt - CNT_W'(1);
                else
                begin
                    // Rising strobe latches data, address and data held
                    next_pins.we_n = 1'b1;
                    next_pins.cs_n = 1'b1;
                    next_step      = step + 3'h1;
                    if (req.op == OP_ID_EXIT || step + 3'h1 == last_step)
                        next_state = S_WR_END;
                    else
                        next_state = S_LOOKUP;
                end
            end
            // Last word: address and data held one cycle past the rise
            S_WR_END:
            begin
                if (req.op == OP_ID_READ)
                begin
                    next_pins = '{1'b0, 1'b0, 1'b1, 1'b1, ADDR_ID_MFR, pins.data};
                    next_cnt  = CNT_W'(READ_CYC);
                    next_state = S_RD_LOW;
                end
                else if (req.op == OP_ID_EXIT)
                begin
                    next_ans.ok = 1'b1;
                    next_state  = S_ANSWER;
                end
                else
                begin
                    // Polling begins after launching edge
                    next_first_poll = 1'b1;
                    next_polls      = '0;
                    next_recheck    = '0;
                    next_pins = '{1'b0, 1'b0, 1'b1, 1'b1, req.addr, pins.data};
                    next_cnt  = CNT_W'(READ_CYC);
                    next_state = S_POLL;
                end
            end
            S_RD_LOW:
            begin
                if (cnt > CNT_W'(1))
                    next_cnt = cnt - CNT_W'(1);
                else
                    next_state = S_RD_DONE;
            end
            S_RD_DONE:
            begin
                next_pins.cs_n = 1'b1;
                next_pins.oe_n = 1'b1;
                if (req.op == OP_ID_READ && id_reads == 2'h0)
                begin
                    next_ans.data  = DATA_LINES_IN;
                    next_id_reads  = 2'h1;
                    next_pins = '{1'b0, 1'b0, 1'b1, 1'b1, ADDR_ID_DEV, pins.data};
                    next_cnt  = CNT_W'(READ_CYC);
                    next_state = S_RD_LOW;
                end
                else
                begin
                    if (req.op == OP_ID_READ)
                        next_ans.data_hi = DATA_LINES_IN;
                    else
                        next_ans.data = DATA_LINES_IN;
                    next_ans.ok = 1'b1;
                    next_state  = S_ANSWER;
                end
            end
            S_POLL:
            begin
                if (cnt > CNT_W'(1))
                    next_cnt = cnt - CNT_W'(1);
                else
                begin
                    // Sample while the read is still gated
                    next_poll_rd   = DATA_LINES_IN;
                    next_pins.cs_n = 1'b1;
                    next_pins.oe_n = 1'b1;
                    next_state     = S_POLL_DONE;
                end
            end
            S_POLL_DONE:
            begin
                next_prev_rd    = poll_rd;
                next_first_poll = 1'b0;
                next_polls      = polls + CNT_W'(1);
                if (!first_poll && status_done(poll_rd, prev_rd, req))
                begin
                    if (recheck == 2'(RECHECK_N))
                    begin
                        next_ans.ok   = 1'b1;
                        next_ans.data = poll_rd;
                        next_state    = S_ANSWER;
                    end
                    else
                        next_recheck = recheck + 2'h1;
                end
                else
                    next_recheck = '0;
                if (polls == CNT_W'(POLL_LIMIT))
                begin
                    next_ans.ok = 1'b0;
                    next_state  = S_ANSWER;
                end
                else if (next_state == S_POLL_DONE)
                begin
                    next_pins.cs_n = 1'b0;
                    next_pins.oe_n = 1'b0;
                    next_cnt       = CNT_W'(READ_CYC);
                    next_state     = S_POLL;
                end
            end
            S_ANSWER:
            begin
                next_ans_valid = 1'b1;
                next_state     = S_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge CLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= S_IDLE;
            req        <= '0;
            pins       <= '{1'b1, 1'b1, 1'b1, 1'b1, '0, '0};
            ans        <= '0;
            ans_valid  <= 1'b0;
            step       <= '0;
            last_step  <= '0;
            cnt        <= '0;
            polls      <= '0;
            recheck    <= '0;
            id_reads   <= '0;
            prev_rd    <= '0;
            poll_rd    <= '0;
            first_poll <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            req        <= next_req;
            pins       <= next_pins;
            ans        <= next_ans;
            ans_valid  <= next_ans_valid;
            step       <= next_step;
            last_step  <= next_last_step;
            cnt        <= next_cnt;
            polls      <= next_polls;
            recheck    <= next_recheck;
            id_reads   <= next_id_reads;
            prev_rd    <= next_prev_rd;
            poll_rd    <= next_poll_rd;
            first_poll <= next_first_poll;
        end
    end

    // Outputs
    assign REQ_READY_OUT       = (state == S_IDLE);
    assign ANS_VALID_OUT       = ans_valid;
    assign ANS_OUT             = ans;
    assign ADDR_OUT            = pins.addr;
    assign CHIP_SEL_N_OUT      = pins.cs_n;
    assign OUT_GATE_N_OUT      = pins.oe_n;
    assign WR_STROBE_N_OUT     = pins.we_n;
    assign DATA_LINES_OUT      = pins.data;
    assign DATA_LINES_OE_N_OUT = pins.drive_n;
endmodule : flash_host

// file: logic/flash_seq_rom.sv
// Purpose: Registered table of command bus words per operation.
// Assumes: Step index up to SEQ_MAX; index SEQ_MAX returns the target word.
// Notes:   Read data come out of a register one cycle after the index.
`timescale 1ns/100ps
module flash_seq_rom
    import flash_host_pkg::*;
(
    // Clock
    input  wire logic      clk_in,
    // Lookup
    input  wire op_t       op_in,
    input  wire logic [2:0] step_in,
    input  wire bus_word_t target_in,
    // Result
    output bus_word_t      word_out
);
    bus_word_t next_word;

    // Command table lookup
    always_comb
    begin
        next_word = target_in;
        unique case (step_in)
            3'h0: next_word = '{ADDR_UNLOCK1, CODE_UNLOCK1};
            3'h1: next_word = '{ADDR_UNLOCK2, CODE_UNLOCK2};
            3'h2:
            begin
                unique case (op_in)
                    OP_PROGRAM: next_word = '{ADDR_UNLOCK1, CODE_PROGRAM};
                    OP_ID_READ: next_word = '{ADDR_UNLOCK1, CODE_ID_IN};
                    OP_ID_EXIT: next_word = '{ADDR_UNLOCK1, CODE_ID_EXIT};
                    default:    next_word = '{ADDR_UNLOCK1, CODE_ERASE};
                endcase
            end
            3'h3:
            begin
                if (op_in == OP_PROGRAM)
                    next_word = target_in;
                else
                    next_word = '{ADDR_UNLOCK1, CODE_UNLOCK1};
            end
            3'h4: next_word = '{ADDR_UNLOCK2, CODE_UNLOCK2};
            3'h5:
            begin
                if (op_in == OP_CHIP_ERASE)
                    next_word = '{ADDR_UNLOCK1, CODE_CHIP};
                else
                    next_word = '{target_in.addr, CODE_SECTOR};
            end
            default: next_word = target_in;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_in)
    begin
        word_out <= next_word;
    end
endmodule : flash_seq_rom

// file: tb/flash_host_properties.sv
// Purpose: Pin protocol checks for the flash host.
// Assumes: Bound to flash_host; one clock domain.
// Notes:   Strobe and read widths follow the two-cycle settings.
`timescale 1ns/100ps
module flash_host_properties
    import flash_host_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK_IN,
    input  wire logic              RESET_N_IN,
    // User side
    input  wire logic              REQ_VALID_IN,
    input  wire logic              REQ_READY_OUT,
    // Flash pins
    input  wire logic [ADDR_W-1:0] ADDR_OUT,
    input  wire logic              CHIP_SEL_N_OUT,
    input  wire logic              OUT_GATE_N_OUT,
    input  wire logic              WR_STROBE_N_OUT,
    input  wire logic [DATA_W-1:0] DATA_LINES_OUT,
    input  wire logic              DATA_LINES_OE_N_OUT
);
    // One domain for every check
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // Write cycle shape
    AST_WRITE_SELECTED: assert property (!WR_STROBE_N_OUT |-> !CHIP_SEL_N_OUT)
        else $error("strobe low without select");
    AST_WRITE_DRIVES: assert property (!WR_STROBE_N_OUT |-> !DATA_LINES_OE_N_OUT)
        else $error("strobe low with data released");
    AST_WRITE_GATE_HIGH: assert property (!WR_STROBE_N_OUT |-> OUT_GATE_N_OUT)
        else $error("output gate low during write");
    AST_STROBE_WIDTH: assert property ($fell(WR_STROBE_N_OUT) |-> !WR_STROBE_N_OUT [*2])
        else $error("write strobe too short");
    AST_ADDR_HELD: assert property (!WR_STROBE_N_OUT && !$past(WR_STROBE_N_OUT)
        |-> $stable(ADDR_OUT) && $stable(DATA_LINES_OUT))
        else $error("address or data moved while strobe low");
    AST_DATA_AT_RISE: assert property ($rose(WR_STROBE_N_OUT)
        |-> $stable(DATA_LINES_OUT) && $stable(ADDR_OUT) && !DATA_LINES_OE_N_OUT)
        else $error("data changed at strobe rise");

    // Read cycle shape and one request at a time
    AST_READ_RELEASED: assert property (!OUT_GATE_N_OUT
        |-> DATA_LINES_OE_N_OUT && !CHIP_SEL_N_OUT)
        else $error("read with host driving data");
    AST_READ_WIDTH: assert property ($fell(OUT_GATE_N_OUT)
        |-> (!OUT_GATE_N_OUT && WR_STROBE_N_OUT) [*2])
        else $error("read gate too short");
    AST_ONE_AT_A_TIME: assert property (REQ_VALID_IN && REQ_READY_OUT |=> !REQ_READY_OUT)
        else $error("ready stayed high after request");
endmodule : flash_host_properties

// file: tb/flash_host_tb.sv
// Purpose: Self-checking bench for the flash host against a flash model.
// Assumes: 10 MHz clock; inputs driven 10 ns after each rising edge.
// Notes:   Last scenario leaves the model busy on purpose.
`timescale 1ns/100ps
module flash_host_tb;
    import flash_host_pkg::*;
    logic              clk       = 1'b0;
    logic              rst_n     = 1'b0;
    logic              req_valid = 1'b0;
    request_t          req       = '0;
    logic              req_ready;
    logic              ans_valid;
    answer_t           ans;
    logic [ADDR_W-1:0] addr;
    logic              cs_n;
    logic              oe_n;
    logic              we_n;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
    logic [DATA_W-1:0] dq_in;
    int                num_errors = 0;
    int                tests_run  = 0;
    int                elapsed    = 0;

    flash_host dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(req_valid),
        .REQ_IN(req), .REQ_READY_OUT(req_ready), .ANS_VALID_OUT(ans_valid),
        .ANS_OUT(ans), .ADDR_OUT(addr), .CHIP_SEL_N_OUT(cs_n), .OUT_GATE_N_OUT(oe_n),
        .WR_STROBE_N_OUT(we_n), .DATA_LINES_OUT(dq_out),
        .DATA_LINES_OE_N_OUT(dq_oe_n), .DATA_LINES_IN(dq_in));
    flash_model flash_u (.addr_in(addr), .cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(we_n),
        .din_in(dq_out), .din_oe_n_in(dq_oe_n), .dout_out(dq_in));

    // Clock
    initial forever #50 clk = ~clk;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One request, then a bounded wait for the answer pulse
    task automatic do_req(input op_t op, input logic [16:0] a, input logic [7:0] d);
        @(posedge clk);
        #10;
        check("ready", {7'h00, req_ready}, 8'h01);
        req = '{op: op, addr: a, data: d};
        req_valid = 1'b1;
        @(posedge clk);
        #10;
        req_valid = 1'b0;
        elapsed = 0;
        while (ans_valid !== 1'b1 && elapsed < 40000)
        begin
            @(posedge clk);
            #10;
            elapsed++;
        end
        if (elapsed >= 40000) num_errors++;
    endtask : do_req

    task automatic read_chk(input logic [16:0] a, input logic [7:0] exp);
        do_req(OP_READ, a, 8'h00);
        check("read data", ans.data, exp);
    endtask : read_chk

    task automatic t_program;
        read_chk(17'h01234, 8'hFF);
        do_req(OP_PROGRAM, 17'h01234, 8'h5A);
        check("program ok", {7'h00, ans.ok}, 8'h01);
        check("program status", ans.data, 8'h5A);
        check("program waited", {7'h00, elapsed >= 80}, 8'h01);
        do_req(OP_PROGRAM, 17'h02000, 8'h3C);
        read_chk(17'h01234, 8'h5A);
    endtask : t_program

    task automatic t_sector;
        do_req(OP_SECTOR_ERASE, 17'h01FFF, 8'h00);
        check("sector ok", {7'h00, ans.ok}, 8'h01);
        check("sector status", ans.data, 8'hFF);
        check("sector waited", {7'h00, elapsed >= 200}, 8'h01);
        read_chk(17'h01234, 8'hFF);
        read_chk(17'h02000, 8'h3C);
    endtask : t_sector

    task automatic t_chip;
        do_req(OP_CHIP_ERASE, 17'h00000, 8'h00);
        check("chip ok", {7'h00, ans.ok}, 8'h01);
        read_chk(17'h02000, 8'hFF);
    endtask : t_chip

    task automatic t_ident;
        do_req(OP_PROGRAM, 17'h00000, 8'h11);
        do_req(OP_ID_READ, 17'h00000, 8'h00);
        check("maker code", ans.data, flash_u.MFR_CODE);
        check("part code", ans.data_hi, flash_u.DEV_CODE);
        do_req(OP_ID_EXIT, 17'h00000, 8'h00);
        read_chk(17'h00000, 8'h11);
    endtask : t_ident

    task automatic t_timeout;
        flash_u.erase_ns = 10000000;
        do_req(OP_CHIP_ERASE, 17'h00000, 8'h00);
        check("stuck erase ok", {7'h00, ans.ok}, 8'h00);
    endtask : t_timeout

    task results;
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        #10;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        t_program();
        t_sector();
        t_chip();
        t_ident();
        t_timeout();
        results();
    end

    // Watchdog
    initial
    begin
        #8000000;
        num_errors++;
        results();
    end
endmodule : flash_host_tb

bind flash_host flash_host_properties chk_u (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .REQ_VALID_IN(REQ_VALID_IN), .REQ_READY_OUT(REQ_READY_OUT), .ADDR_OUT(ADDR_OUT),
    .CHIP_SEL_N_OUT(CHIP_SEL_N_OUT), .OUT_GATE_N_OUT(OUT_GATE_N_OUT),
    .WR_STROBE_N_OUT(WR_STROBE_N_OUT), .DATA_LINES_OUT(DATA_LINES_OUT),
    .DATA_LINES_OE_N_OUT(DATA_LINES_OE_N_OUT));

// file: tb/flash_model.sv
// Purpose: Behavioural byte-wide flash driven by strobe edges.
// Assumes: No pull on data lines; released lines show inverse of last.
// Notes:   Busy times are variables so the bench can stretch them.
`timescale 1ns/100ps
module flash_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] MFR_CODE = 8'h3C, // Arbitrary identity value
    parameter logic [7:0] DEV_CODE = 8'hC3  // Arbitrary identity value
)
(
    // Flash pins
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              cs_n_in,
    input  wire logic              oe_n_in,
    input  wire logic              we_n_in,
    input  wire logic [DATA_W-1:0] din_in,
    input  wire logic              din_oe_n_in,
    output logic [DATA_W-1:0]      dout_out
);
    logic [7:0]        mem [int];
    int                prog_ns  = 8000;
    int                erase_ns = 20000;
    logic              busy     = 1'b0;
    logic              erasing  = 1'b0;
    logic              id_mode  = 1'b0;
    logic              tog      = 1'b0;
    logic [7:0]        pdata    = 8'h00;
    logic [7:0]        last     = 8'h00;
    logic [ADDR_W-1:0] la       = '0;
    realtime           t_fall   = 0;
    int                step     = 0;
    wire               wr_n     = cs_n_in | we_n_in | ~oe_n_in;
    wire               rd_n     = cs_n_in | oe_n_in;

    function automatic logic [7:0] rd(input logic [ADDR_W-1:0] a);
        if (id_mode && a == 17'h00000) return MFR_CODE;
        if (id_mode && a == 17'h00001) return DEV_CODE;
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction : rd

    task automatic start(input int t, input logic e);
        busy = 1'b1;
        erasing = e;
        tog = 1'b1;
        fork
            #(t) busy = 1'b0;
        join_none
    endtask : start

    // Data lines: driven only while selected and gated
    always @(rd_n, addr_in, busy, tog, id_mode, last)
        dout_out = rd_n ? ~last : (busy ? {erasing ? 1'b0 : ~pdata[7], tog, pdata[5:0]}
                                        : rd(addr_in));
    // Last driven value, shown inverted once released
    always @(dout_out)
        if (!rd_n) last = dout_out;
    // Read end advances the toggle bit
    always @(posedge rd_n)
    begin
        if (busy) tog = ~tog;
    end
    // Address latch at the later falling edge
    always @(negedge wr_n)
    begin
        t_fall = $realtime;
        #1 la = addr_in;
    end
    // Command sequencer at the first rising edge
    always @(posedge wr_n)
    begin
        automatic logic [7:0] d = din_oe_n_in ? ~last : din_in;
        automatic logic c5 = la[14:0] == 15'h5555;
        automatic logic c2 = la[14:0] == 15'h2AAA;
        if (!busy && $realtime - t_fall >= 5.0)
        begin
            case (step)
                0: if (d == 8'hF0) id_mode = 1'b0;
                   else step = (c5 && d == 8'hAA) ? 1 : 0;
                1: step = (c2 && d == 8'h55) ? 2 : 0;
                2:
                begin
                    step = (c5 && d == 8'hA0) ? 3 : (c5 && d == 8'h80) ? 4 : 0;
                    if (c5 && d == 8'h90) id_mode = 1'b1;
                    if (c5 && d == 8'hF0) id_mode = 1'b0;
                end
                3:
                begin
                    mem[la] = rd(la) & d;
                    pdata = d;
                    step = 0;
                    start(prog_ns, 1'b0);
                end
                4: step = (c5 && d == 8'hAA) ? 5 : 0;
                5: step = (c2 && d == 8'h55) ? 6 : 0;
                default:
                begin
                    step = 0;
                    if (d == 8'h30)
                    begin
                        foreach (mem[k]) if ((k >> 12) == (la >> 12)) mem[k] = 8'hFF;
                        start(erase_ns, 1'b1);
                    end
                    else if (c5 && d == 8'h10)
                    begin
                        mem.delete();
                        start(erase_ns, 1'b1);
                    end
                end
            endcase
        end
    end
endmodule : flash_model
